// ==== common/bb_pkg.sv ====
// constants for the billboard fallback detach timer
package bb_pkg;
    localparam logic [15:0] addr_cfg        = 16'h413B;
    localparam logic [15:0] addr_cnt_a_lo   = 16'h413C;
    localparam logic [15:0] addr_cnt_a_hi   = 16'h413D;
    localparam logic [15:0] addr_cnt_b_lo   = 16'h413E;
    localparam logic [15:0] addr_cnt_b_hi   = 16'h413F;
    localparam logic [15:0] addr_status     = 16'h4140;
    localparam logic [15:0] addr_desc_base  = 16'h4180;
    localparam int          desc_len        = 48;
    localparam int          desc_aw         = 6;
    localparam logic [15:0] count_reset     = 16'h07D0;
    localparam int          step_ms         = 10;
    localparam int          clk_mhz         = 100;
    localparam int          step_cycles     = step_ms * 1000 * clk_mhz;
    localparam logic [4:0]  pin_sel_reset   = 5'h0A;
    localparam int          cfg_en_bit      = 0;
    localparam int          cfg_sel_lsb     = 1;
    localparam int          detach_cycles   = 16;
    localparam logic [7:0]  desc_num_modes  = 8'h01;
    localparam logic [7:0]  desc_url_idx    = 8'h01;
    localparam logic [7:0]  desc_vconn_hi   = 8'h80;
    localparam logic [7:0]  desc_ver_lo     = 8'h10;
    localparam logic [7:0]  desc_ver_hi     = 8'h01;
    localparam logic [7:0]  desc_svid_hi    = 8'hFF;
    // byte positions in the descriptor array
    localparam int          pos_url         = 3;
    localparam int          pos_num_modes   = 4;
    localparam int          pos_vconn_hi    = 7;
    localparam int          pos_ver_lo      = 40;
    localparam int          pos_ver_hi      = 41;
    localparam int          pos_svid_hi     = 45;
    typedef enum logic [2:0] {st_normal, st_drop_bb, st_billboard, st_drop_std} mode_e;
endpackage : bb_pkg

// ==== logic/desc_mem.sv ====
// descriptor byte array with registered read port
module desc_mem (
    input  wire logic                      clk,     // core clock
    input  wire logic                      resetn,  // async reset, low
    input  wire logic                      wr_en,   // byte write
    input  wire logic [bb_pkg::desc_aw-1:0] wr_addr, // write index
    input  wire logic [7:0]                wr_data, // write byte
    input  wire logic [bb_pkg::desc_aw-1:0] rd_addr, // read index
    output logic      [7:0]                rd_data  // byte, one cycle later
);
    logic [7:0] mem_ff [bb_pkg::desc_len];
    logic [7:0] rd_ff;
    logic [7:0] nxt_rd;

    function automatic logic [7:0] dflt(input int i);
        case (i)
            bb_pkg::pos_url:       dflt = bb_pkg::desc_url_idx;
            bb_pkg::pos_num_modes: dflt = bb_pkg::desc_num_modes;
            bb_pkg::pos_vconn_hi:  dflt = bb_pkg::desc_vconn_hi;
            bb_pkg::pos_ver_lo:    dflt = bb_pkg::desc_ver_lo;
            bb_pkg::pos_ver_hi:    dflt = bb_pkg::desc_ver_hi;
            bb_pkg::pos_svid_hi:   dflt = bb_pkg::desc_svid_hi;
            default:               dflt = 8'h00;
        endcase
    endfunction : dflt

    always_comb begin
        nxt_rd = 8'h00;
        if (int'(rd_addr) < bb_pkg::desc_len) begin
            nxt_rd = mem_ff[rd_addr];
        end
    end

    genvar g;
    generate
        for (g = 0; g < bb_pkg::desc_len; g++) begin : g_byte
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    mem_ff[g] <= dflt(g);
                end else if (wr_en && int'(wr_addr) == g) begin
                    mem_ff[g] <= wr_data;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_ff <= 8'h00;
        end else begin
            rd_ff <= nxt_rd;
        end
    end
    assign rd_data = rd_ff;
endmodule : desc_mem

// ==== logic/step_timer.sv ====
// detach timeout counter in 10 ms steps
module step_timer #(
    parameter int step_cycles = bb_pkg::step_cycles // clock cycles in one 10 ms step
) (
    input  wire logic        clk,     // core clock
    input  wire logic        resetn,  // async reset, low
    input  wire logic        start,   // pulse: load and run
    input  wire logic        stop,    // level: halt, counts keep their value
    input  wire logic [15:0] limit,   // count of steps
    output logic             expired  // one-cycle pulse
);
    localparam logic [23:0] step_last = 24'(step_cycles - 1);
    logic [23:0] pre_ff, nxt_pre;
    logic [15:0] cnt_ff, nxt_cnt;
    logic        run_ff, nxt_run;
    logic        exp_ff, nxt_exp;

    always_comb begin
        nxt_pre = pre_ff;
        nxt_cnt = cnt_ff;
        nxt_run = run_ff;
        nxt_exp = 1'b0;
        if (stop) begin
            nxt_run = 1'b0;
        end else if (start) begin
            nxt_run = 1'b1;
            nxt_pre = 24'h000000;
            nxt_cnt = 16'h0000;
        end else if (run_ff) begin
            if (pre_ff == step_last) begin
                nxt_pre = 24'h000000;
                nxt_cnt = cnt_ff + 16'h0001;
                if (cnt_ff + 16'h0001 >= limit) begin
                    nxt_run = 1'b0;
                    nxt_exp = 1'b1;
                end
            end else begin
                nxt_pre = pre_ff + 24'h000001;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pre_ff <= 24'h000000;
            cnt_ff <= 16'h0000;
            run_ff <= 1'b0;
            exp_ff <= 1'b0;
        end else begin
            pre_ff <= nxt_pre;
            cnt_ff <= nxt_cnt;
            run_ff <= nxt_run;
            exp_ff <= nxt_exp;
        end
    end
    assign expired = exp_ff;
endmodule : step_timer

// ==== logic/billboard_detach.sv ====
// billboard fallback control: detach timers, re-attach sequencing, registers
// Summary of operation
// - a low level on the selected request pin detaches the function, then re-attaches it as billboard.
// - the first timeout starts when the host assigns the function its address.
// - the second timeout starts when the host asks for the alternate-mode string.
// - on second-timeout expiry the function detaches and re-attaches as the standard controller.
// - either timeout expiring, whichever first, causes that same detach and re-attach.
// - timeouts count in 10 ms steps.
// - both timeout counts reset to 07D0h, i.e. 20 s.
// - register 413Fh holds the second timeout's upper byte, read/write.
// - register 413Eh holds the second timeout's lower byte, read/write.
// - the string and URL descriptor fields are writable by configuration.
// - the number-of-alternate-modes field resets to 01h.
module billboard_detach #(
    parameter int step_cycles = bb_pkg::step_cycles // per 10 ms step; shorten only to test expiry
) (
    input  wire logic        clk,          // core clock, 100 MHz
    input  wire logic        resetn,       // async reset, low
    input  wire logic [15:0] reg_addr,     // register address
    input  wire logic [7:0]  reg_wdata,    // write data
    input  wire logic        reg_wr,       // write strobe
    input  wire logic        reg_rd,       // read strobe
    output logic      [7:0]  reg_rdata,    // read data, cycle after strobe
    input  wire logic [16:0] req_pins_n,   // candidate request pins, active low
    input  wire logic        addr_set,     // pulse: host set function address
    input  wire logic        alt_str_req,  // pulse: alt-mode string requested
    input  wire logic [5:0]  desc_idx,     // descriptor byte index to fetch
    output logic [7:0]       desc_byte,    // descriptor byte, one cycle later
    output logic             func_attach,  // function connected to hub port
    output logic             func_bb       // descriptors identify billboard
);
    logic [16:0] pin_s1_ff, pin_s2_ff;
    logic [7:0]  cfg_ff, nxt_cfg;
    logic [15:0] cnt_a_ff, nxt_cnt_a;
    logic [15:0] cnt_b_ff, nxt_cnt_b;
    logic [7:0]  rdata_ff, nxt_rdata;
    logic        rd_desc_ff, nxt_rd_desc;
    bb_pkg::mode_e mode_ff, nxt_mode;
    logic [4:0]  hold_ff, nxt_hold;
    logic        attach_ff, nxt_attach;
    logic        bb_ff, nxt_bb;
    logic        exp_a, exp_b;
    logic        req_low;
    logic        in_bb;
    logic        desc_wr;
    logic [5:0]  desc_waddr;
    logic [7:0]  desc_q;
    logic [4:0]  pin_sel;
    logic [7:0]  status;

    // request pins come from outside: two flops before use
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_s1_ff <= '1;
            pin_s2_ff <= '1;
        end else begin
            pin_s1_ff <= req_pins_n;
            pin_s2_ff <= pin_s1_ff;
        end
    end

    assign pin_sel = cfg_ff[bb_pkg::cfg_sel_lsb +: 5];
    // out-of-range selects never request
    assign req_low = cfg_ff[bb_pkg::cfg_en_bit] && (int'(pin_sel) < 17)
                     && !pin_s2_ff[pin_sel];
    assign in_bb   = (mode_ff == bb_pkg::st_billboard);

    step_timer #(.step_cycles(step_cycles)) u_timer_a (
        .clk     (clk),
        .resetn  (resetn),
        .start   (in_bb && addr_set),
        .stop    (!in_bb),
        .limit   (cnt_a_ff),
        .expired (exp_a)
    );

    step_timer #(.step_cycles(step_cycles)) u_timer_b (
        .clk     (clk),
        .resetn  (resetn),
        .start   (in_bb && alt_str_req),
        .stop    (!in_bb),
        .limit   (cnt_b_ff),
        .expired (exp_b)
    );

    // software reads and writes at base+i, else host fetch index
    assign desc_wr    = reg_wr && reg_addr >= bb_pkg::addr_desc_base
                        && reg_addr < bb_pkg::addr_desc_base + 16'(bb_pkg::desc_len);
    assign desc_waddr = 6'(reg_addr - bb_pkg::addr_desc_base);

    desc_mem u_desc (
        .clk     (clk),
        .resetn  (resetn),
        .wr_en   (desc_wr),
        .wr_addr (desc_waddr),
        .wr_data (reg_wdata),
        .rd_addr (reg_rd ? desc_waddr : desc_idx),
        .rd_data (desc_q)
    );

    assign status = {4'h0, 1'(req_low), 1'(bb_ff), 1'(attach_ff), 1'(in_bb)};

    // register file
    always_comb begin
        nxt_cfg     = cfg_ff;
        nxt_cnt_a   = cnt_a_ff;
        nxt_cnt_b   = cnt_b_ff;
        nxt_rdata   = 8'h00;
        nxt_rd_desc = 1'b0;
        if (reg_wr) begin
            case (reg_addr)
                bb_pkg::addr_cfg:      nxt_cfg = {2'b00, reg_wdata[5:0]};
                bb_pkg::addr_cnt_a_lo: nxt_cnt_a[7:0]  = reg_wdata;
                bb_pkg::addr_cnt_a_hi: nxt_cnt_a[15:8] = reg_wdata;
                bb_pkg::addr_cnt_b_lo: nxt_cnt_b[7:0]  = reg_wdata;
                bb_pkg::addr_cnt_b_hi: nxt_cnt_b[15:8] = reg_wdata;
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                bb_pkg::addr_cfg:      nxt_rdata = cfg_ff;
                bb_pkg::addr_cnt_a_lo: nxt_rdata = cnt_a_ff[7:0];
                bb_pkg::addr_cnt_a_hi: nxt_rdata = cnt_a_ff[15:8];
                bb_pkg::addr_cnt_b_lo: nxt_rdata = cnt_b_ff[7:0];
                bb_pkg::addr_cnt_b_hi: nxt_rdata = cnt_b_ff[15:8];
                bb_pkg::addr_status:   nxt_rdata = status;
                default:               nxt_rd_desc = desc_wr || (reg_addr >= bb_pkg::addr_desc_base
                    && reg_addr < bb_pkg::addr_desc_base + 16'(bb_pkg::desc_len));
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg_ff     <= {2'b00, bb_pkg::pin_sel_reset, 1'b1};
            cnt_a_ff   <= bb_pkg::count_reset;
            cnt_b_ff   <= bb_pkg::count_reset;
            rdata_ff   <= 8'h00;
            rd_desc_ff <= 1'b0;
        end else begin
            cfg_ff     <= nxt_cfg;
            cnt_a_ff   <= nxt_cnt_a;
            cnt_b_ff   <= nxt_cnt_b;
            rdata_ff   <= nxt_rdata;
            rd_desc_ff <= nxt_rd_desc;
        end
    end
    // desc reads come from the memory register, same cycle as others
    assign reg_rdata = rd_desc_ff ? desc_q : rdata_ff;
    assign desc_byte = desc_q;

    // attach sequencer; billboard entry is edge-like: stays until a timeout
    always_comb begin
        nxt_mode   = mode_ff;
        nxt_hold   = hold_ff;
        nxt_attach = attach_ff;
        nxt_bb     = bb_ff;
        case (mode_ff)
            bb_pkg::st_normal: begin
                if (req_low) begin
                    nxt_mode   = bb_pkg::st_drop_bb;
                    nxt_attach = 1'b0;
                    nxt_hold   = 5'(bb_pkg::detach_cycles - 1);
                end
            end
            bb_pkg::st_drop_bb: begin
                if (hold_ff == 5'h00) begin
                    nxt_mode   = bb_pkg::st_billboard;
                    nxt_attach = 1'b1;
                    nxt_bb     = 1'b1;
                end else begin
                    nxt_hold = hold_ff - 5'h01;
                end
            end
            bb_pkg::st_billboard: begin
                if (exp_a || exp_b) begin
                    nxt_mode   = bb_pkg::st_drop_std;
                    nxt_attach = 1'b0;
                    nxt_hold   = 5'(bb_pkg::detach_cycles - 1);
                end
            end
            bb_pkg::st_drop_std: begin
                if (hold_ff == 5'h00) begin
                    nxt_mode   = bb_pkg::st_normal;
                    nxt_attach = 1'b1;
                    nxt_bb     = 1'b0;
                end else begin
                    nxt_hold = hold_ff - 5'h01;
                end
            end
            default: nxt_mode = bb_pkg::st_normal;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode_ff   <= bb_pkg::st_normal;
            hold_ff   <= 5'h00;
            attach_ff <= 1'b1;
            bb_ff     <= 1'b0;
        end else begin
            mode_ff   <= nxt_mode;
            hold_ff   <= nxt_hold;
            attach_ff <= nxt_attach;
            bb_ff     <= nxt_bb;
        end
    end
    assign func_attach = attach_ff;
    assign func_bb     = bb_ff;

    property p_req_detach;
        @(posedge clk) disable iff (!resetn)
        (mode_ff == bb_pkg::st_normal && req_low) |=> !func_attach;
    endproperty
    a_req_detach: assert property (p_req_detach) else $error("no detach on request");

    property p_reattach_bb;
        @(posedge clk) disable iff (!resetn)
        $rose(mode_ff == bb_pkg::st_drop_bb) |-> ##16 (func_attach && func_bb);
    endproperty
    a_reattach_bb: assert property (p_reattach_bb) else $error("billboard attach late");

    property p_expiry_detach;
        @(posedge clk) disable iff (!resetn)
        (in_bb && (exp_a || exp_b)) |=> !func_attach;
    endproperty
    a_expiry_detach: assert property (p_expiry_detach) else $error("no detach on expiry");

    property p_reattach_std;
        @(posedge clk) disable iff (!resetn)
        $rose(mode_ff == bb_pkg::st_drop_std) |-> ##16 (func_attach && !func_bb);
    endproperty
    a_reattach_std: assert property (p_reattach_std) else $error("standard attach late");

    property p_wr_hi;
        @(posedge clk) disable iff (!resetn)
        (reg_wr && reg_addr == bb_pkg::addr_cnt_b_hi) |=> cnt_b_ff[15:8] == $past(reg_wdata);
    endproperty
    a_wr_hi: assert property (p_wr_hi) else $error("upper byte not stored");

    property p_wr_lo;
        @(posedge clk) disable iff (!resetn)
        (reg_wr && reg_addr == bb_pkg::addr_cnt_b_lo) ##1 (reg_rd && reg_addr == bb_pkg::addr_cnt_b_lo)
        |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_wr_lo: assert property (p_wr_lo) else $error("lower byte readback wrong");

    property p_no_expiry_idle;
        @(posedge clk) disable iff (!resetn)
        !in_bb |=> !(exp_a || exp_b) || in_bb;
    endproperty
    a_no_expiry_idle: assert property (p_no_expiry_idle) else $error("timer ran outside billboard");

    property p_bb_stable;
        @(posedge clk) disable iff (!resetn)
        (in_bb && !exp_a && !exp_b) |=> func_attach && func_bb;
    endproperty
    a_bb_stable: assert property (p_bb_stable) else $error("billboard dropped early");

    property p_drop_bb_low;
        @(posedge clk) disable iff (!resetn)
        (mode_ff == bb_pkg::st_drop_bb) |-> !func_attach;
    endproperty
    a_drop_bb_low: assert property (p_drop_bb_low) else $error("attached in detach");

    property p_bb_entry;
        @(posedge clk) disable iff (!resetn)
        $rose(func_bb) |-> $past(mode_ff == bb_pkg::st_drop_bb) && func_attach;
    endproperty
    a_bb_entry: assert property (p_bb_entry) else $error("billboard without detach");

    property p_drop_std_low;
        @(posedge clk) disable iff (!resetn)
        (mode_ff == bb_pkg::st_drop_std) |-> !func_attach;
    endproperty
    a_drop_std_low: assert property (p_drop_std_low) else $error("attached in std detach");

    // normal mode keeps the standard descriptors until a request arrives
    property p_normal_steady;
        @(posedge clk) disable iff (!resetn)
        (mode_ff == bb_pkg::st_normal && !req_low) |=> func_attach && !func_bb;
    endproperty
    a_normal_steady: assert property (p_normal_steady) else $error("standard not kept");

    property p_rd_hi;
        @(posedge clk) disable iff (!resetn)
        (reg_rd && reg_addr == bb_pkg::addr_cnt_b_hi) |=> reg_rdata == $past(cnt_b_ff[15:8]);
    endproperty
    a_rd_hi: assert property (p_rd_hi) else $error("upper byte read wrong");

    property p_rd_lo;
        @(posedge clk) disable iff (!resetn)
        (reg_rd && reg_addr == bb_pkg::addr_cnt_b_lo) |=> reg_rdata == $past(cnt_b_ff[7:0]);
    endproperty
    a_rd_lo: assert property (p_rd_lo) else $error("lower byte read wrong");

    // reserved config bits are dropped on write, so they must read zero
    property p_cfg_reserved;
        @(posedge clk) disable iff (!resetn)
        (reg_rd && reg_addr == bb_pkg::addr_cfg) |=> reg_rdata[7:6] == 2'b00;
    endproperty
    a_cfg_reserved: assert property (p_cfg_reserved) else $error("reserved config bits set");
endmodule : billboard_detach

// ==== bench/bb_host_model.sv ====
// host side model: address assignment, alt-mode string request, descriptor fetch
module bb_host_model (
    input  wire logic       clk,         // core clock
    output logic            addr_set,    // address-set pulse
    output logic            alt_str_req, // string request pulse
    output logic [5:0]      desc_idx,    // byte index to fetch
    input  wire logic [7:0] desc_byte    // fetched byte
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        addr_set    = 1'b0;
        alt_str_req = 1'b0;
        desc_idx    = 6'h00;
    end

    task automatic set_address();
        @(posedge clk);
        addr_set <= 1'b1;
        @(posedge clk);
        addr_set <= 1'b0;
    endtask : set_address

    task automatic ask_alt_string();
        @(posedge clk);
        alt_str_req <= 1'b1;
        @(posedge clk);
        alt_str_req <= 1'b0;
    endtask : ask_alt_string

    // index is a level; the byte is taken just after the edge that registers it
    task automatic fetch(input logic [5:0] idx, output logic [7:0] b);
        @(posedge clk);
        desc_idx <= idx;
        @(posedge clk);
        #1;
        b = desc_byte;
    endtask : fetch
endmodule : bb_host_model

// ==== bench/tb_billboard_detach.sv ====
// self-checking bench for the billboard fallback detach control
module tb_billboard_detach;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk;
    logic        resetn;
    logic [15:0] reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic [16:0] req_pins_n;
    logic        addr_set;
    logic        alt_str_req;
    logic [5:0]  desc_idx;
    logic [7:0]  desc_byte;
    logic        func_attach;
    logic        func_bb;
    int          miscompares;
    int          checks;
    logic [7:0]  b;
    localparam int tb_step = 20; // short step so both timeouts fit the run


    billboard_detach #(.step_cycles(tb_step)) i_billboard_detach (
        .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .req_pins_n(req_pins_n), .addr_set(addr_set), .alt_str_req(alt_str_req),
        .desc_idx(desc_idx), .desc_byte(desc_byte), .func_attach(func_attach),
        .func_bb(func_bb)
    );

    bb_host_model i_bb_host_model (
        .clk(clk), .addr_set(addr_set), .alt_str_req(alt_str_req),
        .desc_idx(desc_idx), .desc_byte(desc_byte)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic wrap_up();
        if (miscompares == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", name, exp, got);
            miscompares++;
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        chk("reg_rdata", exp, reg_rdata);
    endtask : rd

    // write then read back with no gap between the strobes
    task automatic wr_rd(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b1;
        @(posedge clk);
        reg_rd    <= 1'b0;
        #1;
        chk("reg_rdata", d, reg_rdata);
    endtask : wr_rd

    task automatic wait_att(input logic val, input int lim);
        int n;
        n = 0;
        while (func_attach !== val && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("func_attach", {7'h00, val}, {7'h00, func_attach});
    endtask : wait_att

    // checks the two mode levels over a stretch of cycles
    task automatic hold(input int n, input logic att, input logic bb);
        logic ok;
        ok = 1'b1;
        repeat (n) begin
            @(posedge clk);
            #1;
            if (func_attach !== att || func_bb !== bb) ok = 1'b0;
        end
        chk("mode_hold", 8'h01, {7'h00, ok});
    endtask : hold

    task automatic do_reset();
        @(posedge clk);
        resetn <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk("attach_in_reset", 8'h01, {7'h00, func_attach});
        chk("bb_in_reset", 8'h00, {7'h00, func_bb});
        resetn <= 1'b1;
    endtask : do_reset

    function automatic logic [7:0] dflt(input int i);
        case (i)
            bb_pkg::pos_url:       return bb_pkg::desc_url_idx;
            bb_pkg::pos_num_modes: return bb_pkg::desc_num_modes;
            bb_pkg::pos_vconn_hi:  return bb_pkg::desc_vconn_hi;
            bb_pkg::pos_ver_lo:    return bb_pkg::desc_ver_lo;
            bb_pkg::pos_ver_hi:    return bb_pkg::desc_ver_hi;
            bb_pkg::pos_svid_hi:   return bb_pkg::desc_svid_hi;
            default:               return 8'h00;
        endcase
    endfunction : dflt

    initial begin
        int cyc;
        cyc = 0;
        forever begin
            @(posedge clk);
            cyc++;
            if (cyc == 20000) begin
                miscompares++;
                wrap_up();
            end
        end
    end

    initial begin
        miscompares = 0;
        checks      = 0;
        resetn      = 1'b0;
        reg_addr    = 16'h0000;
        reg_wdata   = 8'h00;
        reg_wr      = 1'b0;
        reg_rd      = 1'b0;
        req_pins_n  = 17'h1FFFF;
        do_reset();
        rd(bb_pkg::addr_cnt_a_lo, 8'hD0);
        rd(bb_pkg::addr_cnt_a_hi, 8'h07);
        rd(bb_pkg::addr_cnt_b_lo, 8'hD0);
        rd(bb_pkg::addr_cnt_b_hi, 8'h07);
        rd(bb_pkg::addr_cfg, 8'h15);
        rd(bb_pkg::addr_status, 8'h02);
        rd(16'h4000, 8'h00);
        wr(bb_pkg::addr_cnt_b_hi, 8'hA5);
        wr(bb_pkg::addr_cnt_b_lo, 8'h5A);
        wr(16'h4000, 8'hFF);
        rd(bb_pkg::addr_cnt_b_hi, 8'hA5);
        rd(bb_pkg::addr_cnt_b_lo, 8'h5A);
        rd(16'h4000, 8'h00);
        wr_rd(bb_pkg::addr_cnt_b_lo, 8'h3C);
        for (int i = 0; i < bb_pkg::desc_len; i++) begin
            i_bb_host_model.fetch(6'(i), b);
            chk("desc_byte", dflt(i), b);
            rd(bb_pkg::addr_desc_base + 16'(i), dflt(i));
        end
        wr(bb_pkg::addr_desc_base + 16'(bb_pkg::pos_url), 8'h5A);
        wr(bb_pkg::addr_desc_base + 16'h0008, 8'hC3);
        i_bb_host_model.fetch(6'(bb_pkg::pos_url), b);
        chk("desc_url", 8'h5A, b);
        i_bb_host_model.fetch(6'h08, b);
        chk("desc_cfg0", 8'hC3, b);
        // one step for timer b, so it elapses long before timer a
        wr(bb_pkg::addr_cnt_b_lo, 8'h01);
        wr(bb_pkg::addr_cnt_b_hi, 8'h00);
        @(posedge clk);
        req_pins_n[10] <= 1'b0;
        wait_att(1'b0, 8);
        wait_att(1'b1, 40);
        chk("func_bb", 8'h01, {7'h00, func_bb});
        rd(bb_pkg::addr_status, 8'h0F);
        @(posedge clk);
        req_pins_n[10] <= 1'b1;
        i_bb_host_model.set_address();
        hold(500, 1'b1, 1'b1);
        i_bb_host_model.ask_alt_string();
        hold(tb_step, 1'b1, 1'b1);
        wait_att(1'b0, 2);
        wait_att(1'b1, 16);
        chk("func_bb", 8'h00, {7'h00, func_bb});
        do_reset();
        rd(bb_pkg::addr_cnt_b_lo, 8'hD0);
        wr(bb_pkg::addr_cfg, 8'h14);
        @(posedge clk);
        req_pins_n[10] <= 1'b0;
        hold(40, 1'b1, 1'b0);
        @(posedge clk);
        req_pins_n[10] <= 1'b1;
        wr(bb_pkg::addr_cfg, 8'hFF);
        rd(bb_pkg::addr_cfg, 8'h3F);
        wr(bb_pkg::addr_cfg, 8'h03);
        rd(bb_pkg::addr_cfg, 8'h03);
        @(posedge clk);
        req_pins_n[1] <= 1'b0;
        wait_att(1'b0, 8);
        wait_att(1'b1, 40);
        chk("func_bb", 8'h01, {7'h00, func_bb});
        @(posedge clk);
        req_pins_n[1] <= 1'b1;
        wr(bb_pkg::addr_cnt_a_lo, 8'h02);
        wr(bb_pkg::addr_cnt_a_hi, 8'h00);
        i_bb_host_model.set_address();
        hold(2 * tb_step, 1'b1, 1'b1);
        wait_att(1'b0, 2);
        wait_att(1'b1, 16);
        chk("func_bb", 8'h00, {7'h00, func_bb});
        wrap_up();
    end
endmodule : tb_billboard_detach
